// *** src/fault_latch.sv ***
// Sticky fault latch over the protection event inputs
`timescale 1ns/1ps
module fault_latch #(
   parameter int N = 7
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [N-1:0] events,
   output logic fault
);
   initial begin
      if (N < 1) $error("fault_latch needs an event");
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault <= 1'b0;
      end else if (|events) begin
         fault <= 1'b1;
      end
   end
endmodule : fault_latch

// *** src/param_store.sv ***
// Small persistent parameter store with registered read data
`timescale 1ns/1ps
module param_store #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic we,
   input wire logic [1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   // No reset: the parent's factory load rewrites all four slots after every reset
   logic [WIDTH-1:0] mem [DEPTH];
   initial begin
      if (DEPTH != 4) $error("param_store depth must be 4");
   end
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : param_store

// *** src/tec_run_map.svh ***
// Register map, reset values and thresholds of the run-permit block
// Summary of operation
// - Run request high runs, low stops
// - Listed protection events raise a fault
// - Fault output high on fault, else low
// - Fault latched until restart, not cause removal
// - Warning on above 60C, off below 58C
// - Shutdown above 80C, clears at 58C, but the latched fault blocks restart until reset
// - Honoured lock: open input refuses running
// - Power-up honours the safety lock
// - Lock-ignored state disregards lock input
// - Thermistor nominal defaults 10k, reloaded after every reset
// - Factory limits 15A, 40V, beta 3988
// - Scale 0.61 for 1k, else 0.762
// - Monitor uses setpoint voltage relation
// - Power-up: analogue params, pin run, lock honoured
`ifndef TEC_RUN_MAP_SVH
`define TEC_RUN_MAP_SVH
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_THERM 8'h0c
`define OFS_ILIMIT 8'h10
`define OFS_VLIMIT 8'h14
`define OFS_BETA 8'h18
`define OFS_SCALE 8'h1c
`define OFS_BOARD 8'h20
`define CTL_LOCK_IGNORE 0
`define CTL_DIGITAL_PARAMS 1
`define CTL_DIGITAL_RUN 2
`define CTL_RUN_CMD 3
`define ST_FAULT 0
`define ST_WARN 1
`define ST_SHUTDOWN 2
`define ST_LOCKED 3
`define ST_BITS 4
`define RST_THERM_OHM 16'h2710
`define RST_ILIMIT_DA 16'h0096
`define RST_VLIMIT_DV 16'h0190
`define RST_BETA 16'h0f94
`define THERM_1K_OHM 16'h03e8
`define SCALE_1K_MILLI 16'h0262
`define SCALE_OTHER_MILLI 16'h02fa
`define WARN_ON_C 8'h3c
`define WARN_OFF_C 8'h3a
`define SHUT_ON_C 8'h50
`define SHUT_OFF_C 8'h3a
`endif

// *** src/tec_run_permit.sv ***
// Run permission, protection and parameter logic of the cooler controller
`timescale 1ns/1ps
`include "tec_run_map.svh"
module tec_run_permit
   import tec_run_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic run_request_input,
   input wire logic lock_input_open,
   input wire logic overcurrent,
   input wire logic overvoltage,
   input wire logic short_circuit,
   input wire logic module_self_heat,
   input wire logic temp_too_fast,
   input wire logic temp_wrong_dir,
   input wire logic [7:0] board_temp_c,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic fault_output,
   output logic board_heat_warning,
   output logic module_drive_enable,
   output logic [15:0] conversion_scale,
   output logic use_digital_params,
   output logic irq
);
   run_state_t state;
   run_state_t next_state;
   logic [3:0] control;
   logic [`ST_BITS-1:0] status;
   logic [`ST_BITS-1:0] mask;
   logic fault;
   logic shutdown;
   logic warn;
   logic permit;
   logic run_req;
   logic access;
   logic rd_status;
   logic [`ST_BITS-1:0] events_now;
   logic [`ST_BITS-1:0] prev_events;
   logic [15:0] therm_ohm;
   logic [15:0] store_rdata;
   logic store_we;
   logic [1:0] store_waddr;
   logic [1:0] store_raddr;
   logic [1:0] read_sel;
   logic [1:0] init_cnt;
   logic init_done;
   logic wb_hit;

   fault_latch #(.N(7)) u_fault (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .events({overcurrent, overvoltage, short_circuit, module_self_heat,
               board_temp_c > `SHUT_ON_C, temp_too_fast, temp_wrong_dir}),
      .fault(fault)
   );

   // Store slots: 0 thermistor, 1 current, 2 voltage, 3 beta
   param_store #(.DEPTH(4), .WIDTH(16)) u_store (
      .sys_clk(sys_clk),
      .we(store_we),
      .waddr(store_waddr),
      .wdata(init_done ? wb_dat_i[15:0] : next_default(init_cnt)),
      .raddr(store_raddr),
      .rdata(store_rdata)
   );

   function automatic logic [15:0] next_default(input logic [1:0] idx);
      case (idx)
         2'd0: next_default = `RST_THERM_OHM;
         2'd1: next_default = `RST_ILIMIT_DA;
         2'd2: next_default = `RST_VLIMIT_DV;
         default: next_default = `RST_BETA;
      endcase
   endfunction : next_default

   // Factory load after reset, one slot per cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         init_cnt <= 2'd0;
         init_done <= 1'b0;
      end else if (!init_done) begin
         init_cnt <= init_cnt + 2'd1;
         if (init_cnt == 2'd3) begin
            init_done <= 1'b1;
         end
      end
   end

   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wb_hit = wb_adr_i[7:0] <= `OFS_BOARD && wb_adr_i[1:0] == 2'b00
      && wb_adr_i[31:8] == 24'h000000;

   always_comb begin
      store_we = 1'b0;
      store_waddr = 2'd0;
      if (!init_done) begin
         store_we = 1'b1;
         store_waddr = init_cnt;
      end else if (access && wb_we_i && wb_sel_i[0] && wb_sel_i[1]) begin
         if (wb_adr_i[7:0] == `OFS_THERM) begin
            store_we = 1'b1;
            store_waddr = 2'd0;
         end else if (wb_adr_i[7:0] == `OFS_ILIMIT) begin
            store_we = 1'b1;
            store_waddr = 2'd1;
         end else if (wb_adr_i[7:0] == `OFS_VLIMIT) begin
            store_we = 1'b1;
            store_waddr = 2'd2;
         end else if (wb_adr_i[7:0] == `OFS_BETA) begin
            store_we = 1'b1;
            store_waddr = 2'd3;
         end
      end
   end

   // Read slot picks the addressed word, else keeps the thermistor in view
   always_comb begin
      store_raddr = 2'd0;
      if (access && !wb_we_i) begin
         if (wb_adr_i[7:0] == `OFS_ILIMIT) begin
            store_raddr = 2'd1;
         end else if (wb_adr_i[7:0] == `OFS_VLIMIT) begin
            store_raddr = 2'd2;
         end else if (wb_adr_i[7:0] == `OFS_BETA) begin
            store_raddr = 2'd3;
         end
      end
   end

   // Thermistor value copy tracks slot 0 for the scale choice
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         therm_ohm <= `RST_THERM_OHM;
      end else if (store_we && store_waddr == 2'd0) begin
         therm_ohm <= init_done ? wb_dat_i[15:0] : `RST_THERM_OHM;
      end
   end

   // Same scale for setpoint and monitor conversions
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         conversion_scale <= `SCALE_OTHER_MILLI;
      end else if (therm_ohm == `THERM_1K_OHM) begin
         conversion_scale <= `SCALE_1K_MILLI;
      end else begin
         conversion_scale <= `SCALE_OTHER_MILLI;
      end
   end

   // Control comes up honouring lock, analogue params, pin run
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         control <= 4'h0;
         mask <= '0;
      end else if (access && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i[7:0] == `OFS_CONTROL) begin
            control <= wb_dat_i[3:0];
         end else if (wb_adr_i[7:0] == `OFS_MASK) begin
            mask <= wb_dat_i[`ST_BITS-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         use_digital_params <= 1'b0;
      end else begin
         use_digital_params <= control[`CTL_DIGITAL_PARAMS];
      end
   end

   assign run_req = control[`CTL_DIGITAL_RUN] ? control[`CTL_RUN_CMD]
      : run_request_input;

   // Warning with hysteresis, holds in the band
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         warn <= 1'b0;
      end else if (board_temp_c > `WARN_ON_C) begin
         warn <= 1'b1;
      end else if (board_temp_c < `WARN_OFF_C) begin
         warn <= 1'b0;
      end
   end

   // Over-temperature stop, released at 58C or below
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shutdown <= 1'b0;
      end else if (board_temp_c > `SHUT_ON_C) begin
         shutdown <= 1'b1;
      end else if (board_temp_c <= `SHUT_OFF_C) begin
         shutdown <= 1'b0;
      end
   end

   // Lock input open refuses running unless ignored
   assign permit = run_req && !fault && !shutdown
      && (control[`CTL_LOCK_IGNORE] || !lock_input_open);

   always_comb begin
      next_state = state;
      case (state)
         RUN_IDLE: begin
            if (fault) next_state = RUN_FAULTED;
            else if (permit) next_state = RUN_ACTIVE;
         end
         RUN_ACTIVE: begin
            if (fault) next_state = RUN_FAULTED;
            else if (shutdown) next_state = RUN_COOLDOWN;
            else if (!permit) next_state = RUN_IDLE;
         end
         RUN_COOLDOWN: begin
            if (fault) next_state = RUN_FAULTED;
            else if (!shutdown) next_state = RUN_IDLE;
         end
         default: next_state = RUN_FAULTED;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= RUN_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         module_drive_enable <= 1'b0;
         fault_output <= 1'b0;
         board_heat_warning <= 1'b0;
      end else begin
         module_drive_enable <= next_state == RUN_ACTIVE && permit;
         fault_output <= fault;
         board_heat_warning <= warn;
      end
   end

   // Sticky status on rising events; read clears, set wins
   assign events_now = {lock_input_open && !control[`CTL_LOCK_IGNORE],
                        shutdown, warn, fault};
   assign rd_status = access && !wb_we_i && wb_hit
      && wb_adr_i[7:0] == `OFS_STATUS;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_events <= '0;
         status <= '0;
         irq <= 1'b0;
      end else begin
         prev_events <= events_now;
         status <= (rd_status ? '0 : status) | (events_now & ~prev_events);
         irq <= |(status & mask);
      end
   end

   // Classic Wishbone slave, one wait cycle for the store read
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         read_sel <= 2'd0;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (wb_ack_o || wb_err_o) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         read_sel <= 2'd0;
      end else if (access && !wb_hit) begin
         wb_err_o <= 1'b1;
      end else if (access && read_sel == 2'd0) begin
         read_sel <= 2'd1;
         wb_dat_o <= '0;
         if (wb_adr_i[7:0] == `OFS_CONTROL) begin
            wb_dat_o <= {28'h0000000, control};
         end else if (wb_adr_i[7:0] == `OFS_STATUS) begin
            wb_dat_o <= {28'h0000000, status};
         end else if (wb_adr_i[7:0] == `OFS_MASK) begin
            wb_dat_o <= {28'h0000000, mask};
         end else if (wb_adr_i[7:0] == `OFS_SCALE) begin
            wb_dat_o <= {16'h0000, conversion_scale};
         end else if (wb_adr_i[7:0] == `OFS_BOARD) begin
            wb_dat_o <= {22'h000000, state, board_temp_c};
         end else begin
            read_sel <= 2'd2;
         end
      end else if (access) begin
         wb_ack_o <= 1'b1;
         if (read_sel == 2'd2) begin
            wb_dat_o <= {16'h0000, store_rdata};
         end
      end
   end

   a_fault_output_set: assert property (@(posedge sys_clk)
      disable iff (!reset_n) fault |=> fault_output)
      else $error("fault output not raised");
   a_fault_sticky: assert property (@(posedge sys_clk)
      disable iff (!reset_n) fault_output |=> fault_output)
      else $error("fault output dropped");
   a_warn_on: assert property (@(posedge sys_clk)
      disable iff (!reset_n) board_temp_c > 8'd60 |=> ##1 board_heat_warning)
      else $error("warning not raised");
   a_warn_hold: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      board_temp_c >= 8'd58 && board_temp_c <= 8'd60 && warn |=> warn)
      else $error("warning left band early");
   // Low level must hold in the band as well, or the pin would chatter
   a_warn_hold_low: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      board_temp_c >= `WARN_OFF_C && board_temp_c <= `WARN_ON_C && !warn
      |=> !warn)
      else $error("warning rose inside band");
   a_shutdown_stop: assert property (@(posedge sys_clk)
      disable iff (!reset_n) board_temp_c > 8'd80 |=> ##1 !module_drive_enable)
      else $error("drive on while overheated");
   a_shutdown_hold: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      shutdown && board_temp_c > `SHUT_OFF_C |=> shutdown)
      else $error("shutdown released too warm");
   a_lock_refuse: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      lock_input_open && !control[0] |=> !module_drive_enable)
      else $error("drive on with lock open");
   a_run_stop: assert property (@(posedge sys_clk)
      disable iff (!reset_n) !run_req |=> !module_drive_enable)
      else $error("drive on without request");
   a_fault_stops_drive: assert property (@(posedge sys_clk)
      disable iff (!reset_n) fault |=> !module_drive_enable)
      else $error("drive on with fault latched");
   sequence s_therm_one_k;
      therm_ohm == 16'h03e8;
   endsequence
   a_scale_select: assert property (@(posedge sys_clk)
      disable iff (!reset_n) s_therm_one_k ##1 s_therm_one_k
      |-> conversion_scale == 16'h0262)
      else $error("wrong scale for 1k thermistor");
endmodule : tec_run_permit

// *** src/tec_run_pkg.sv ***
// Types of the run-permit block
package tec_run_pkg;
   typedef enum logic [1:0] {
      RUN_IDLE = 2'b00,
      RUN_ACTIVE = 2'b01,
      RUN_FAULTED = 2'b10,
      RUN_COOLDOWN = 2'b11
   } run_state_t;
endpackage : tec_run_pkg

// *** tb/tec_panel_model.sv ***
// Host panel model driving the control and protection pins
`timescale 1ns/1ps
module tec_panel_model (
   input wire logic run_switch,
   input wire logic lock_grounded,
   input wire logic [5:0] event_lines,
   input wire logic [7:0] board_temp,
   output logic run_request_input,
   output logic lock_input_open,
   output logic overcurrent,
   output logic overvoltage,
   output logic short_circuit,
   output logic module_self_heat,
   output logic temp_too_fast,
   output logic temp_wrong_dir,
   output logic [7:0] board_temp_c
);
   // Enable pin pulled down, so run starts low
   assign run_request_input = run_switch;
   // Interlock pulled up: open reads high until grounded
   assign lock_input_open = !lock_grounded;
   assign {temp_wrong_dir, temp_too_fast, module_self_heat, short_circuit,
      overvoltage, overcurrent} = event_lines;
   assign board_temp_c = board_temp;
endmodule : tec_panel_model

// *** tb/tec_run_permit_test.sv ***
// Self-checking bench of the run-permit block
`timescale 1ns/1ps
`include "tec_run_map.svh"
module tec_run_permit_test;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] dat = 32'h0;
   logic [3:0] sel = 4'hf;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic run_request_input, lock_input_open, overcurrent, overvoltage;
   logic short_circuit, module_self_heat, temp_too_fast, temp_wrong_dir;
   logic [7:0] board_temp_c;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, wb_err_o, fault_output, board_heat_warning, irq;
   logic module_drive_enable, use_digital_params;
   logic [15:0] conversion_scale;
   int miscompares = 0;
   int n_compared = 0;
   logic [7:0] ofs [5] = '{`OFS_THERM, `OFS_ILIMIT, `OFS_VLIMIT, `OFS_BETA,
      `OFS_SCALE};
   logic [15:0] rv [5] = '{`RST_THERM_OHM, `RST_ILIMIT_DA, `RST_VLIMIT_DV,
      `RST_BETA, `SCALE_OTHER_MILLI};

   logic run_switch = 1'b0;
   logic lock_grounded = 1'b0;
   logic [5:0] event_lines = 6'h00;
   logic [7:0] board_temp = 8'h19;

   always #20 sys_clk = ~sys_clk;

   tec_panel_model panel (.run_switch, .lock_grounded, .event_lines,
      .board_temp, .run_request_input, .lock_input_open,
      .overcurrent, .overvoltage, .short_circuit, .module_self_heat,
      .temp_too_fast, .temp_wrong_dir, .board_temp_c);

   tec_run_permit DUT (.sys_clk, .reset_n, .run_request_input,
      .lock_input_open, .overcurrent, .overvoltage, .short_circuit,
      .module_self_heat, .temp_too_fast, .temp_wrong_dir, .board_temp_c,
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o, .wb_ack_o, .wb_err_o,
      .fault_output, .board_heat_warning, .module_drive_enable,
      .conversion_scale, .use_digital_params, .irq);

   task give_verdict();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // Waits for ack or err, never assuming a latency
   task wb(input logic [31:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      @(posedge sys_clk);
      adr <= a;
      we <= w;
      dat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 40);
      q = wb_dat_o;
      e = wb_err_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 40) begin
         miscompares++;
      end
   endtask : wb

   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      wb({24'h0, a}, 1'b0, 32'h0, q, e);
      chk(q, exp);
   endtask : rd

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      wb({24'h0, a}, 1'b1, d, q, e);
   endtask : wr

   task do_reset();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
   endtask : do_reset

   // Outputs lag their cause by up to three registers
   task settle();
      repeat (4) @(posedge sys_clk);
   endtask : settle

   task set_run(input logic v);
      @(posedge sys_clk);
      run_switch <= v;
   endtask : set_run

   task set_lock(input logic closed);
      @(posedge sys_clk);
      lock_grounded <= closed;
   endtask : set_lock

   task set_event(input int i, input logic v);
      @(posedge sys_clk);
      event_lines[i] <= v;
   endtask : set_event

   task set_temp(input logic [7:0] t);
      @(posedge sys_clk);
      board_temp <= t;
   endtask : set_temp

   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      give_verdict();
   end

   initial begin
      logic [31:0] q;
      logic e;
      do_reset();
      rd(`OFS_CONTROL, 32'h0);
      for (int i = 0; i < 5; i++) rd(ofs[i], {16'h0, rv[i]});
      chk({16'h0, conversion_scale}, {16'h0, `SCALE_OTHER_MILLI});
      chk({31'h0, use_digital_params}, 32'h0);
      wb(32'h24, 1'b0, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      wb(32'h6, 1'b1, 32'h1, q, e);
      chk({31'h0, e}, 32'h1);
      // Run permission and the lock
      set_run(1'b1);
      settle();
      chk({31'h0, module_drive_enable}, 32'h0);
      set_lock(1'b1);
      settle();
      chk({31'h0, module_drive_enable}, 32'h1);
      set_run(1'b0);
      settle();
      chk({31'h0, module_drive_enable}, 32'h0);
      set_run(1'b1);
      set_lock(1'b0);
      settle();
      chk({31'h0, module_drive_enable}, 32'h0);
      // Control needs byte lane 0, so this write is dropped
      sel <= 4'he;
      wr(`OFS_CONTROL, 32'h1 << `CTL_LOCK_IGNORE);
      sel <= 4'hf;
      settle();
      chk({31'h0, module_drive_enable}, 32'h0);
      wr(`OFS_CONTROL, 32'h1 << `CTL_LOCK_IGNORE);
      settle();
      chk({31'h0, module_drive_enable}, 32'h1);
      wr(`OFS_CONTROL, 32'h0);
      set_lock(1'b1);
      // Digital run select overrides the pin
      set_run(1'b0);
      wr(`OFS_CONTROL, 32'he);
      settle();
      chk({31'h0, module_drive_enable}, 32'h1);
      chk({31'h0, use_digital_params}, 32'h1);
      wr(`OFS_CONTROL, 32'h6);
      settle();
      chk({31'h0, module_drive_enable}, 32'h0);
      wr(`OFS_CONTROL, 32'h0);
      set_run(1'b1);
      settle();
      chk({31'h0, use_digital_params}, 32'h0);
      chk({31'h0, module_drive_enable}, 32'h1);
      // Warning hysteresis and its interrupt
      wr(`OFS_MASK, 32'h1 << `ST_WARN);
      set_temp(8'd61);
      settle();
      chk({31'h0, board_heat_warning}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      set_temp(8'd59);
      settle();
      chk({31'h0, board_heat_warning}, 32'h1);
      wb({24'h0, `OFS_STATUS}, 1'b0, 32'h0, q, e);
      chk({31'h0, q[`ST_WARN]}, 32'h1);
      settle();
      chk({31'h0, irq}, 32'h0);
      set_temp(8'd57);
      settle();
      chk({31'h0, board_heat_warning}, 32'h0);
      set_temp(8'd59);
      settle();
      chk({31'h0, board_heat_warning}, 32'h0);
      // Thermistor value selects the scale
      wr(`OFS_THERM, {16'h0, `THERM_1K_OHM});
      settle();
      rd(`OFS_THERM, {16'h0, `THERM_1K_OHM});
      chk({16'h0, conversion_scale}, {16'h0, `SCALE_1K_MILLI});
      // Board overheat stops and latches
      set_temp(8'd81);
      settle();
      chk({31'h0, module_drive_enable}, 32'h0);
      chk({31'h0, fault_output}, 32'h1);
      // Latched fault shows as the faulted state code
      rd(`OFS_BOARD, {22'h0, 2'b10, 8'd81});
      rd(`OFS_STATUS, 32'h7);
      set_temp(8'd58);
      settle();
      chk({31'h0, module_drive_enable}, 32'h0);
      do_reset();
      settle();
      chk({31'h0, fault_output}, 32'h0);
      chk({31'h0, module_drive_enable}, 32'h1);
      // Each of the six panel event lines latches until restart
      for (int i = 0; i < 6; i++) begin
         set_event(i, 1'b1);
         settle();
         chk({31'h0, fault_output}, 32'h1);
         chk({31'h0, module_drive_enable}, 32'h0);
         set_event(i, 1'b0);
         settle();
         chk({31'h0, fault_output}, 32'h1);
         do_reset();
         settle();
         chk({31'h0, fault_output}, 32'h0);
      end
      give_verdict();
   end
endmodule : tec_run_permit_test
